// [goc_defines.vh]
// constants for the overcurrent comparator 1 configuration block
`ifndef GOC_DEFINES_VH
`define GOC_DEFINES_VH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define GOC_OFF_CONFIG    12'h000
`define GOC_OFF_PROTECT   12'h004
`define GOC_OFF_STATUS    12'h008
`define GOC_OFF_MASK      12'h00C
`define GOC_OFF_VERSION   12'h010

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define GOC_BIT_ACTION    7
`define GOC_BIT_ENABLE    6
`define GOC_CONFIG_RESET  8'h00
`define GOC_DAC_TOP_V4    2'h3
`define GOC_DAC_TOP_V5    1'h1
// status bits: 0 write refused, 1 protect set
`define GOC_STAT_REFUSED  0
`define GOC_STAT_LOCKED   1
`define GOC_STAT_WIDTH    2

`endif

// [goc_dac_code.v]
// threshold DAC code formation for comparator 1
`timescale 1ns/1ps
`include "goc_defines.vh"

module goc_dac_code (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // configuration
  input  wire       versionFive,
  input  wire [4:0] thresholdField,
  // DAC code
  output reg  [5:0] dacCode
);

  always @(posedge clk) begin
    if (rst) begin
      dacCode <= 6'h00;
    end else if (versionFive) begin
      dacCode <= {`GOC_DAC_TOP_V5, thresholdField};
    end else begin
      dacCode <= {`GOC_DAC_TOP_V4, thresholdField[3:0]};
    end
  end

endmodule // goc_dac_code

// [goc_overcurrent_config.v]
// APB register bank for overcurrent comparator 1 configuration
`timescale 1ns/1ps
`include "goc_defines.vh"

module goc_overcurrent_config #(
  parameter VERSION_FIVE_DEFAULT = 1
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // comparator controls
  output reg         overcurrentActionSelect,
  output reg         overcurrentComparatorEnable,
  output wire [5:0]  overcurrentThresholdCode,
  output reg         driverWriteProtect,
  output reg         driverVersionFive,
  // interrupt
  output reg         irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [4:0]                 thresholdField;
  reg  [`GOC_STAT_WIDTH-1:0] status;
  reg  [`GOC_STAT_WIDTH-1:0] mask;
  reg  [`GOC_STAT_WIDTH-1:0] next_status;
  reg  [31:0]                next_rdata;
  reg                        next_err;
  reg                        versionInit;
  reg                        next_action;
  reg                        next_enable;
  reg  [4:0]                 next_threshold;

  // access completes in the access phase; pready is a one-cycle pulse
  wire access  = psel && penable && !pready;
  wire wrEn    = access && pwrite;
  wire rdEn    = access && !pwrite;

  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire mapped = hit(paddr, `GOC_OFF_CONFIG) || hit(paddr, `GOC_OFF_PROTECT) ||
                hit(paddr, `GOC_OFF_STATUS) || hit(paddr, `GOC_OFF_MASK) ||
                hit(paddr, `GOC_OFF_VERSION);

  wire cfgWrite = wrEn && hit(paddr, `GOC_OFF_CONFIG);

  // ------------------------------------------------------------
  // register selects, write strobes and the status read strobe
  // ------------------------------------------------------------
  wire selConfig    = hit(paddr, `GOC_OFF_CONFIG);
  wire selProtect   = hit(paddr, `GOC_OFF_PROTECT);
  wire selStatus    = hit(paddr, `GOC_OFF_STATUS);
  wire selMask      = hit(paddr, `GOC_OFF_MASK);
  wire selVersion   = hit(paddr, `GOC_OFF_VERSION);
  wire protectWrite = wrEn && selProtect && pwdata[0];
  wire maskWrite    = wrEn && selMask;
  wire versionWrite = wrEn && selVersion && !driverWriteProtect;
  wire statusRead   = rdEn && selStatus;

  // events that set sticky status bits; both come from bus writes only
  wire refusedEvent = cfgWrite && driverWriteProtect;
  wire lockedEvent  = protectWrite && !driverWriteProtect;

  // ------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------
  // a refused write leaves every field as it was; bit 4 is stored only in
  // version five, so that a later version switch cannot expose a stale bit
  always @* begin
    next_action    = overcurrentActionSelect;
    next_enable    = overcurrentComparatorEnable;
    next_threshold = thresholdField;
    if (cfgWrite && !driverWriteProtect) begin
      next_action    = pwdata[`GOC_BIT_ACTION];
      next_enable    = pwdata[`GOC_BIT_ENABLE];
      next_threshold = {pwdata[4] & driverVersionFive, pwdata[3:0]};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      overcurrentActionSelect     <= 1'b0;
      overcurrentComparatorEnable <= 1'b0;
      thresholdField              <= 5'h00;
    end else begin
      overcurrentActionSelect     <= next_action;
      overcurrentComparatorEnable <= next_enable;
      thresholdField              <= next_threshold;
    end
  end

  // ------------------------------------------------------------
  // write protect and version select
  // ------------------------------------------------------------
  // protect is write-once; only reset clears it
  always @(posedge clk) begin
    if (rst) begin
      driverWriteProtect <= 1'b0;
    end else if (protectWrite) begin
      driverWriteProtect <= 1'b1;
    end
  end

  // strap taken on the first edge after reset; a bus write in that same
  // cycle still wins, and the select freezes once protect is set
  always @(posedge clk) begin
    if (rst) begin
      versionInit       <= 1'b1;
      driverVersionFive <= 1'b0;
    end else begin
      versionInit <= 1'b0;
      if (versionWrite) begin
        driverVersionFive <= pwdata[0];
      end else if (versionInit) begin
        driverVersionFive <= (VERSION_FIVE_DEFAULT != 0);
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt mask
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      mask <= {`GOC_STAT_WIDTH{1'b0}};
    end else if (maskWrite) begin
      mask <= pwdata[`GOC_STAT_WIDTH-1:0];
    end
  end

  goc_dac_code u_dac (
    .clk            (clk),
    .rst            (rst),
    .versionFive    (driverVersionFive),
    .thresholdField (thresholdField),
    .dacCode        (overcurrentThresholdCode)
  );

  // ------------------------------------------------------------
  // sticky status: set wins over read clear
  // ------------------------------------------------------------
  always @* begin
    next_status = status;
    if (statusRead) begin
      next_status = {`GOC_STAT_WIDTH{1'b0}};
    end
    if (refusedEvent) begin
      next_status[`GOC_STAT_REFUSED] = 1'b1;
    end
    if (lockedEvent) begin
      next_status[`GOC_STAT_LOCKED] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // config as software sees it: bit 5 is never stored, bit 4 shows only in
  // version five even if it was written before a switch to version four
  function [7:0] cfgImage;
    input       act;
    input       ena;
    input       v5;
    input [4:0] thr;
    begin
      cfgImage = {act, ena, 1'b0, thr[4] & v5, thr[3:0]};
    end
  endfunction

  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = !mapped;
    if (selConfig) begin
      next_rdata[7:0] = cfgImage(overcurrentActionSelect, overcurrentComparatorEnable,
                                 driverVersionFive, thresholdField);
    end else if (selProtect) begin
      next_rdata[0] = driverWriteProtect;
    end else if (selStatus) begin
      next_rdata[`GOC_STAT_WIDTH-1:0] = status;
    end else if (selMask) begin
      next_rdata[`GOC_STAT_WIDTH-1:0] = mask;
    end else if (selVersion) begin
      next_rdata[0] = driverVersionFive;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      status  <= 2'h0;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      status  <= next_status;
      pready  <= access;
      pslverr <= access && next_err;
      if (rdEn) begin
        prdata <= next_rdata;
      end
      irq <= |(next_status & mask);
    end
  end

endmodule // goc_overcurrent_config

// [goc_overcurrent_config_props.sv]
// assertions for the overcurrent configuration register bank
`timescale 1ns/1ps
module goc_overcurrent_config_props (
  // bus
  input logic        clk,
  input logic        rst,
  input logic        psel,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  // controls
  input logic        overcurrentActionSelect,
  input logic        overcurrentComparatorEnable,
  input logic [5:0]  overcurrentThresholdCode,
  input logic        driverWriteProtect,
  input logic        driverVersionFive
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // accepted configuration write, at its completing edge
  // ----
  sequence s_wr;
    pready && psel && pwrite && paddr == 12'h000 && !driverWriteProtect;
  endsequence
  a_lock_hold: assert property ($past(driverWriteProtect) |->
    $stable({overcurrentActionSelect, overcurrentComparatorEnable, overcurrentThresholdCode}))
    else $error("config changed while protected");
  a_enable_bit: assert property (s_wr |-> overcurrentComparatorEnable == pwdata[6])
    else $error("enable bit wrong");
  a_action_bit: assert property (s_wr |-> overcurrentActionSelect == pwdata[7])
    else $error("action bit wrong");
  a_code_four: assert property (s_wr ##0 !driverVersionFive |=>
    overcurrentThresholdCode == {2'h3, $past(pwdata[3:0])}) else $error("v4 code wrong");
  a_code_five: assert property (s_wr ##0 driverVersionFive |=>
    overcurrentThresholdCode == {1'h1, $past(pwdata[4:0])}) else $error("v5 code wrong");
  a_pad_zero: assert property (pready && psel && !pwrite && paddr == 12'h000 |->
    prdata[31:8] == 0 && !prdata[5] && (driverVersionFive || !prdata[4]))
    else $error("unallocated bits not zero");
endmodule // goc_overcurrent_config_props
bind goc_overcurrent_config goc_overcurrent_config_props u_props (.clk, .rst, .psel, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .overcurrentActionSelect, .overcurrentComparatorEnable,
  .overcurrentThresholdCode, .driverWriteProtect, .driverVersionFive);

// [tb_top.sv]
// self-checking bench for the overcurrent configuration register bank
`timescale 1ns/1ps
`include "goc_defines.vh"
module tb_top;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d, o, seed = 74;
  logic        pready, pslverr, irq, driverWriteProtect, driverVersionFive;
  logic        overcurrentActionSelect, overcurrentComparatorEnable;
  logic [5:0]  overcurrentThresholdCode;
  bit          ver5 = 1;
  int          fails = 0, cmp_count = 0;
  goc_overcurrent_config #(.VERSION_FIVE_DEFAULT(1)) DUT (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .overcurrentActionSelect, .irq,
    .overcurrentComparatorEnable, .overcurrentThresholdCode, .driverWriteProtect,
    .driverVersionFive);
  initial begin
    forever #5 clk = ~clk;
  end
  // ----
  // helpers
  // ----
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [5:0] codeExp(bit v, logic [31:0] w);
    return v ? {1'h1, w[4:0]} : {2'h3, w[3:0]};
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // no bound of its own: only the watchdog ends a wait for a silent slave
  task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    chk("versionStrap", 1, driverVersionFive);
    for (int i = 0; i < 24; i++) begin
      if (i == 12) begin
        ver5 = 0;
        apb(1, `GOC_OFF_VERSION, 0);
        chk("versionFour", 0, driverVersionFive);
      end
      seed = xs(seed);
      d = (i % 12 == 0) ? 32'hFFFFFFFF : seed;
      apb(1, `GOC_OFF_CONFIG, d);
      apb(0, `GOC_OFF_CONFIG, 0);
      chk("readback", {24'h0, d[7:6], 1'h0, d[4] & ver5, d[3:0]}, rd);
      o = {overcurrentActionSelect, overcurrentComparatorEnable, overcurrentThresholdCode};
      chk("outputs", {24'h0, d[7:6], codeExp(ver5, d)}, o);
    end
    apb(0, 12'h0FC, 0);
    chk("slverr", 1, err);
    chk("protectOff", 0, driverWriteProtect);
    apb(1, `GOC_OFF_PROTECT, 1);
    chk("protectOn", 1, driverWriteProtect);
    apb(1, `GOC_OFF_CONFIG, ~d);
    apb(1, `GOC_OFF_VERSION, 1);
    chk("versionKept", 0, driverVersionFive);
    apb(0, `GOC_OFF_CONFIG, 0);
    chk("locked", {24'h0, d[7:6], 1'h0, d[4] & ver5, d[3:0]}, rd);
    chk("okSlverr", 0, err);
    o = {overcurrentActionSelect, overcurrentComparatorEnable, overcurrentThresholdCode};
    chk("lockedOutputs", {24'h0, d[7:6], codeExp(ver5, d)}, o);
    chk("irqMasked", 0, irq);
    apb(1, `GOC_OFF_MASK, 1);
    repeat (2) @(posedge clk);
    chk("irqRaised", 1, irq);
    apb(0, `GOC_OFF_STATUS, 0);
    chk("status", 3, rd);
    repeat (2) @(posedge clk);
    chk("irqCleared", 0, irq);
    apb(1, `GOC_OFF_MASK, 2);
    apb(1, `GOC_OFF_CONFIG, d);
    repeat (2) @(posedge clk);
    chk("irqOtherMask", 0, irq);
    apb(0, `GOC_OFF_STATUS, 0);
    chk("statusRefused", 1, rd);
    wrap_up;
  end
  initial begin
    #20us;
    fails++;
    wrap_up;
  end
endmodule // tb_top
